// [design/ptarc_top.v]
// ptarc_top.v: arbitration port answering an external radio with a grant
// assumes: pad inputs synchronous to i_ref_clk; local wlan supplies its busy level
`timescale 1ns/1ns
`include "ptarc_regs.vh"
module ptarc_top (
  input  wire       i_ref_clk,
  input  wire       i_reset,
  input  wire [1:0] i_pad_mode,
  input  wire       i_pri_two_bit,
  input  wire       i_dir_pin_used,
  input  wire       i_freq_pin_used,
  input  wire       i_wlan_busy,
  input  wire       i_ext_radio_request,
  input  wire       i_ext_radio_priority,
  input  wire       i_pad22_in,
  input  wire       i_pad18_in,
  input  wire       i_serial_coex_out,
  input  wire [4:0] i_gpio_out,
  input  wire [4:0] i_gpio_oe,
  output wire [4:0] o_pad_out,
  output wire [4:0] o_pad_oe_n,
  output reg        o_ext_radio_grant,
  output reg        o_ext_radio_direction,
  output reg        o_ext_radio_freq_overlap,
  output reg  [1:0] o_ext_radio_pri_level,
  output reg        o_serial_coex_in
);
  reg  [3:0] state;
  reg  [3:0] next_state;
  reg  [1:0] cnt;
  reg  [1:0] pri;
  reg        dir;
  wire       pta_on    = (i_pad_mode == `PTARC_MODE_PTA);
  wire       serial_on = (i_pad_mode == `PTARC_MODE_SERIAL);
  wire [1:0] pri_need  = (i_pri_two_bit == `PTARC_PRI_TWO) ? `PTARC_CNT_TWO : `PTARC_CNT_ONE;
  wire       dir_now   = i_dir_pin_used ? i_pad22_in : dir;
  wire       overlap   = ~i_freq_pin_used | (i_pad18_in == `PTARC_OVERLAP);
  // pending request wins when not overlapping or high priority or wlan idle
  wire       win       = ~overlap | (pri >= `PTARC_PRI_WIN) | ~i_wlan_busy;

  // sequence: idle, priority bits, optional trailing direction, decide
  always @* begin
    next_state = state;
    case (state)
      `PTARC_ST_IDLE:   if (pta_on && i_ext_radio_request) next_state = `PTARC_ST_PRI;
      `PTARC_ST_PRI:    if (cnt == pri_need - 2'h1)
                          next_state = i_dir_pin_used ? `PTARC_ST_DECIDE : `PTARC_ST_DIR;
      `PTARC_ST_DIR:    next_state = `PTARC_ST_DECIDE;
      `PTARC_ST_DECIDE: next_state = `PTARC_ST_DECIDE;
      default:          next_state = `PTARC_ST_IDLE;
    endcase
    if (!i_ext_radio_request || !pta_on)
      next_state = `PTARC_ST_IDLE;
  end

  // sampling and grant; request drop ends the grant at once
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      state                    <= `PTARC_ST_IDLE;
      cnt                      <= `PTARC_CNT_ZERO;
      pri                      <= `PTARC_CNT_ZERO;
      dir                      <= `PTARC_DIR_RX;
      o_ext_radio_grant        <= 1'b0;
      o_ext_radio_direction    <= `PTARC_DIR_RX;
      o_ext_radio_freq_overlap <= 1'b0;
      o_ext_radio_pri_level    <= `PTARC_CNT_ZERO;
      o_serial_coex_in         <= 1'b0;
    end else begin
      state            <= next_state;
      o_serial_coex_in <= serial_on & i_pad22_in;
      if (state == `PTARC_ST_IDLE) begin
        cnt <= `PTARC_CNT_ZERO;
        pri <= `PTARC_CNT_ZERO;
      end
      if (state == `PTARC_ST_PRI && i_ext_radio_request) begin
        pri <= {pri[0], i_ext_radio_priority}; // msb first
        cnt <= cnt + 2'h1;
      end
      if (state == `PTARC_ST_DIR)
        dir <= i_ext_radio_priority;
      // grant only in decide with request still high
      o_ext_radio_grant <= (state == `PTARC_ST_DECIDE) && (next_state == `PTARC_ST_DECIDE) && win;
      o_ext_radio_direction    <= dir_now;
      o_ext_radio_freq_overlap <= overlap;
      o_ext_radio_pri_level    <= pri;
    end
  end

  // pads 18..22: only grant (20) and serial out (18) are driven by functions
  wire [4:0] func_sel   = {serial_on | pta_on, pta_on, pta_on, pta_on, serial_on | pta_on};
  wire [4:0] func_drive = {1'b0, 1'b0, pta_on, 1'b0, serial_on};
  wire [4:0] func_out   = {1'b0, 1'b0, o_ext_radio_grant, 1'b0, i_serial_coex_out};
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_pad
      ptarc_pad u_pad (
        .i_ref_clk    (i_ref_clk),
        .i_reset      (i_reset),
        .i_func_drive (func_drive[g]),
        .i_func_out   (func_out[g]),
        .i_gpio_oe    (i_gpio_oe[g]),
        .i_gpio_out   (i_gpio_out[g]),
        .i_func_sel   (func_sel[g]),
        .o_pad_out    (o_pad_out[g]),
        .o_pad_oe_n   (o_pad_oe_n[g])
      );
    end
  endgenerate
endmodule // ptarc_top

// [design/ptarc_regs.vh]
// ptarc_regs.vh: constants for the radio coexistence arbitration port
// assumes: included by design files of the ptarc block only
`ifndef PTARC_REGS_VH
`define PTARC_REGS_VH
// pad mode select (shared pads)
`define PTARC_MODE_GPIO   2'h0
`define PTARC_MODE_PTA    2'h1
`define PTARC_MODE_SERIAL 2'h2
// priority bit counts
`define PTARC_PRI_ONE     1'b0
`define PTARC_PRI_TWO     1'b1
// pta state encodings, one-hot
`define PTARC_ST_IDLE     4'h1
`define PTARC_ST_PRI      4'h2
`define PTARC_ST_DIR      4'h4
`define PTARC_ST_DECIDE   4'h8
// sample counter
`define PTARC_CNT_ZERO    2'h0
`define PTARC_CNT_ONE     2'h1
`define PTARC_CNT_TWO     2'h2
// direction codes and frequency overlap level
`define PTARC_DIR_TX      1'b1
`define PTARC_DIR_RX      1'b0
`define PTARC_OVERLAP     1'b1
// priority threshold that wins over local traffic
`define PTARC_PRI_WIN     2'h2
`endif

// [design/ptarc_pad.v]
// ptarc_pad.v: one shared pad cell with function select
// assumes: owning module supplies pad direction per function
`timescale 1ns/1ns
`include "ptarc_regs.vh"
module ptarc_pad (
  input  wire       i_ref_clk,
  input  wire       i_reset,
  input  wire       i_func_drive,
  input  wire       i_func_out,
  input  wire       i_gpio_oe,
  input  wire       i_gpio_out,
  input  wire       i_func_sel,
  output reg        o_pad_out,
  output reg        o_pad_oe_n
);
  // registered mux; oe is low while driving
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_pad_out  <= 1'b0;
      o_pad_oe_n <= 1'b1;
    end else if (i_func_sel) begin
      o_pad_out  <= i_func_out;
      o_pad_oe_n <= ~i_func_drive;
    end else begin
      o_pad_out  <= i_gpio_out;
      o_pad_oe_n <= ~i_gpio_oe;
    end
  end
endmodule // ptarc_pad

// [tb/ptarc_radio.sv]
// ptarc_radio.sv: external radio, request then priority bits msb first
// assumes: shares the device clock; priority pad pulled up
`timescale 1ns/1ns
module ptarc_radio (
  input  wire i_ref_clk,
  output reg  o_req = 0,
  output reg  o_pri = 1
);
  integer k;
  // first bit stands an extra edge while the request is taken
  task send(input [1:0] b, input integer n);
    begin
      @(posedge i_ref_clk) o_req <= 1;
      o_pri <= b[n-1];
      for (k = n - 1; k >= 0; k = k - 1) @(posedge i_ref_clk) o_pri <= b[k];
    end
  endtask
  // released line floats back to the pull-up
  task drop;
    @(posedge i_ref_clk) {o_req, o_pri} <= 2'h1;
  endtask
endmodule // ptarc_radio

// [tb/ptarc_checker.sv]
// ptarc_checker.sv: pin assertions for the arbitration port
// assumes: bound into ptarc_top, one clock
`timescale 1ns/1ns
module ptarc_checker (
  input wire       i_ref_clk,
  input wire       i_reset,
  input wire [1:0] i_pad_mode,
  input wire       i_ext_radio_request,
  input wire       i_serial_coex_out,
  input wire [4:0] o_pad_out,
  input wire [4:0] o_pad_oe_n,
  input wire       o_ext_radio_grant,
  input wire       i_freq_pin_used,
  input wire       i_pad18_in,
  input wire       i_pad22_in,
  input wire       o_ext_radio_freq_overlap,
  input wire       o_serial_coex_in
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  // grant may lag the request by one cycle only
  a_no_req_grant: assert property (
    !i_ext_radio_request |=> !o_ext_radio_grant) else $error("grant without request");
  a_grant_pad_on: assert property (
    i_pad_mode == 2'h1 |=> !o_pad_oe_n[2]) else $error("grant pad undriven");
  a_serial_pad: assert property (
    i_pad_mode == 2'h2 |=> !o_pad_oe_n[0] && o_pad_out[0] == $past(i_serial_coex_out)) else $error("serial pad");
  // serial input pad is passed through one register
  a_serial_in_pad: assert property (
    i_pad_mode == 2'h2 |=> o_serial_coex_in == $past(i_pad22_in)) else $error("serial in pad");
  a_overlap_follow: assert property (
    i_freq_pin_used |=> o_ext_radio_freq_overlap == $past(i_pad18_in)) else $error("overlap not followed");
  // grant pad repeats the grant flop one cycle later
  a_grant_pad_val: assert property (
    i_pad_mode == 2'h1 |=> o_pad_out[2] == $past(o_ext_radio_grant)) else $error("grant pad value");
endmodule // ptarc_checker
bind ptarc_top ptarc_checker u_chk (.*);

// [tb/test_pta_radio_coexistence.sv]
// test_pta_radio_coexistence.sv: priority, direction and pad checks
// assumes: radio model on request and priority
`timescale 1ns/1ns
module test_pta_radio_coexistence;
  reg        i_ref_clk = 0, i_reset = 1, i_pri_two_bit = 1, i_dir_pin_used = 1, i_wlan_busy = 1;
  reg        i_freq_pin_used = 1, i_pad22_in = 1, i_pad18_in = 1, i_serial_coex_out = 1;
  reg  [1:0] i_pad_mode = 2'h1;
  wire       i_ext_radio_request, i_ext_radio_priority, o_ext_radio_grant, o_ext_radio_direction;
  wire       o_ext_radio_freq_overlap, o_serial_coex_in;
  wire [1:0] o_ext_radio_pri_level;
  wire [4:0] o_pad_out, o_pad_oe_n;
  integer    fail_count = 0, cmp_count = 0;
  // 25 MHz
  always #20 i_ref_clk = ~i_ref_clk;
  ptarc_top uut (.*, .i_gpio_out(5'h00), .i_gpio_oe(5'h00));
  ptarc_radio peer (.i_ref_clk, .o_req(i_ext_radio_request), .o_pri(i_ext_radio_priority));
  task chk(input [8*12-1:0] name, input [1:0] seen, input [1:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("MISMATCH %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  // grant flop due two edges after the last bit, grant pad three; direction only means something when granted
  task ask(input [1:0] b, input integer n, input [1:0] gd);
    begin
      peer.send(b, n);
      repeat (3) @(posedge i_ref_clk);
      #1 chk("grant_dir", {o_ext_radio_grant, o_ext_radio_direction & o_ext_radio_grant}, gd);
      chk("pri_level", o_ext_radio_pri_level, i_pri_two_bit ? b : {1'b0, b[1]});
      chk("overlap", {1'b0, o_ext_radio_freq_overlap}, {1'b0, ~i_freq_pin_used | i_pad18_in});
      chk("grant_pad", {o_pad_oe_n[2], o_pad_out[2]}, {1'b0, gd[1]});
      peer.drop;
      repeat (2) @(posedge i_ref_clk);
    end
  endtask
  task t_busy;
    begin
      ask(2'h1, 2, 2'h0);
      ask(2'h2, 2, 2'h3);
      @(posedge i_ref_clk) i_pad18_in <= 0;
      ask(2'h0, 2, 2'h3);
    end
  endtask
  task t_nodir;
    begin
      @(posedge i_ref_clk) {i_wlan_busy, i_pri_two_bit, i_dir_pin_used} <= 3'h0;
      ask(2'h2, 2, 2'h2);
      ask(2'h1, 2, 2'h3);
    end
  endtask
  task end_sim;
    begin
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  // reset, arbitration cases, then serial mode for the pad check
  initial begin
    repeat (5) @(posedge i_ref_clk);
    i_reset <= 0;
    t_busy;
    t_nodir;
    i_pad_mode <= 2'h2;
    repeat (2) @(posedge i_ref_clk);
    #1 chk("serial_in", {1'b0, o_serial_coex_in}, {1'b0, i_pad22_in});
    chk("serial_pad", {o_pad_oe_n[0], o_pad_out[0]}, {1'b0, i_serial_coex_out});
    end_sim;
  end
endmodule // test_pta_radio_coexistence
